// File: hw/motion_start_override_control.sv
/*
  Stored-operation start and override controller with an Avalon-MM register
  slave. Assumes a host that holds start until ready falls, and a motion
  engine that reports completion on i_op_done.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_start_override_control
  import start_ctl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_start,
  input wire logic i_alt_start,
  input wire logic [7:0] i_data_number_select,
  input wire logic i_op_done,
  input wire logic i_forward_reverse_operation,
  output logic o_stored_op_ready,
  output logic o_op_start,
  output logic [7:0] o_op_data_number,
  output logic o_op_running,
  output logic o_sequence_clear,
  output logic o_excitation_request,
  output logic o_ramp_method
);
  logic [31:0] cfg_r;
  logic bus_ack;
  logic running_r;
  logic waiting_release_r;
  logic take;
  logic is_override;
  start_req_if req ();

  start_edge_detect u_edge (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_start(i_start),
    .i_alt_start(i_alt_start),
    .i_alt_enable(cfg_r[CFG_ALT_FUNC_BIT]),
    .i_data_number_select(i_data_number_select),
    .o_req(req)
  );

  // a start is taken when idle, or while running only if override is on
  assign take = (req.start_pulse || req.alt_pulse) && !waiting_release_r &&
    (!running_r || cfg_r[CFG_OVR_BIT]);
  assign is_override = take && running_r;

  // bus slave: one wait cycle, then answer; waitrequest is a flop of its own
  // so that the output carries no gate behind the register
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end
  // answer cycle: the master samples waitrequest low at the edge that ends it
  assign bus_ack = !o_avs_waitrequest;

  // configuration register
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= CFG_RESET;
    end else if (bus_ack && i_avs_write && i_avs_address == OFS_CONFIG) begin
      cfg_r <= i_avs_writedata & CFG_MASK;
    end
  end

  // read data
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !bus_ack) begin
      case (i_avs_address)
        OFS_CONFIG: o_avs_readdata <= cfg_r;
        OFS_STATUS: o_avs_readdata <= {29'h0, waiting_release_r, running_r, o_stored_op_ready};
        OFS_ACTIVE: o_avs_readdata <= {24'h0, o_op_data_number};
        default: o_avs_readdata <= UNMAPPED_RD;
      endcase
    end
  end

  // operation state
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      running_r <= 1'b0;
      o_op_data_number <= 8'h00;
      o_op_start <= 1'b0;
      o_sequence_clear <= 1'b0;
    end else begin
      o_op_start <= take;
      o_sequence_clear <= is_override;
      if (take) begin
        running_r <= 1'b1;
        o_op_data_number <= req.dnum;
      end else if (i_op_done) begin
        running_r <= 1'b0;
      end
    end
  end

  // ready handshake: drop on start, restore on release with override on, else on done
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      waiting_release_r <= 1'b0;
      o_stored_op_ready <= 1'b1;
    end else if (take) begin
      waiting_release_r <= 1'b1;
      o_stored_op_ready <= 1'b0;
    end else if (waiting_release_r && !req.start_level) begin
      waiting_release_r <= 1'b0;
      o_stored_op_ready <= cfg_r[CFG_OVR_BIT] || !running_r || i_op_done;
    end else if (!waiting_release_r && (i_op_done || !running_r)) begin
      o_stored_op_ready <= 1'b1;
    end
  end
  assign o_op_running = running_r;

  // excitation request and ramp method outputs
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_excitation_request <= 1'b0;
      o_ramp_method <= RAMP_ACCEL_DECEL;
    end else begin
      o_excitation_request <= cfg_r[CFG_AUTO_EXC_BIT] && i_forward_reverse_operation;
      o_ramp_method <= cfg_r[CFG_RAMP_BIT];
    end
  end

  // handshake steps, as seen from the controller
  sequence s_start_taken;
    take;
  endsequence
  sequence s_started_ready_low;
    o_op_start && !o_stored_op_ready && o_op_running;
  endsequence
  sequence s_start_held;
    waiting_release_r && req.start_level;
  endsequence
  sequence s_ready_kept_low;
    waiting_release_r && !o_stored_op_ready;
  endsequence
  sequence s_override_taken;
    take && running_r;
  endsequence
  sequence s_override_applied;
    o_op_start && o_sequence_clear && o_op_running;
  endsequence

  // start handshake
  a_ready_drops: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    take |=> !o_stored_op_ready)
    else $error("ready did not fall");
  a_start_hshake: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_start_taken |=> s_started_ready_low)
    else $error("start not carried out");
  a_ready_held: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_start_held |=> s_ready_kept_low)
    else $error("ready rose while start held");
  a_ready_back: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (waiting_release_r && !req.start_level && cfg_r[CFG_OVR_BIT] && !take)
    |=> o_stored_op_ready)
    else $error("ready not restored");
  a_ready_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!running_r && !waiting_release_r && !take) |=> o_stored_op_ready)
    else $error("ready low while idle");
  a_dnum_load: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    take |=> o_op_data_number == $past(i_data_number_select))
    else $error("wrong data");
  a_dnum_keep: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !take |=> $stable(o_op_data_number))
    else $error("data number changed without start");

  // override gating and its effects
  a_no_ovr_start: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (running_r && !cfg_r[CFG_OVR_BIT] && !i_op_done) |=> !o_op_start)
    else $error("start taken while running");
  a_seq_clear: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    s_override_taken |=> s_override_applied)
    else $error("no clear");
  a_no_clear_idle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (take && !running_r) |=> !o_sequence_clear)
    else $error("clear without override");
  a_ovr_run: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (running_r && cfg_r[CFG_OVR_BIT] && req.start_pulse && !waiting_release_r)
    |=> o_op_start ##0 running_r)
    else $error("override lost");
  a_alt_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!cfg_r[CFG_ALT_FUNC_BIT] && !req.start_pulse) |-> !take)
    else $error("alt taken");

  // setting outputs
  a_auto_exc: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (cfg_r[CFG_AUTO_EXC_BIT] && i_forward_reverse_operation) |=> o_excitation_request)
    else $error("no excitation");
  a_excite_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !cfg_r[CFG_AUTO_EXC_BIT] |=> !o_excitation_request)
    else $error("excitation without setting");
  a_ramp_out: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ##1 o_ramp_method == $past(cfg_r[CFG_RAMP_BIT]))
    else $error("ramp method");
  a_cfg_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (bus_ack && i_avs_write && i_avs_address == OFS_CONFIG)
    |=> cfg_r == $past(i_avs_writedata & CFG_MASK))
    else $error("config write lost");

  // bus answer: one wait cycle, then back to waiting
  a_bus_one_wait: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus answer late");
  a_bus_release: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("bus answer held");
endmodule : motion_start_override_control
`default_nettype wire

// File: hw/start_edge_detect.sv
/*
  Rising-edge detector for the start and alternate select-start inputs;
  captures the data-number select inputs at the edge.
  Assumes inputs synchronous to i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module start_edge_detect (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_alt_start,
  input wire logic i_alt_enable,
  input wire logic [7:0] i_data_number_select,
  start_req_if.src o_req
);
  logic start_d_r;
  logic alt_d_r;
  logic [7:0] dnum_r;

  // previous input levels
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_d_r <= 1'b0;
      alt_d_r <= 1'b0;
    end else begin
      start_d_r <= i_start;
      alt_d_r <= i_alt_start;
    end
  end

  // select lines latched only on a start edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dnum_r <= 8'h00;
    end else if ((i_start && !start_d_r) || (i_alt_enable && i_alt_start && !alt_d_r)) begin
      dnum_r <= i_data_number_select;
    end
  end

  // edges and captured number, combined
  assign o_req.start_pulse = i_start && !start_d_r;
  assign o_req.alt_pulse = i_alt_enable && i_alt_start && !alt_d_r;
  assign o_req.dnum = ((i_start && !start_d_r) || (i_alt_enable && i_alt_start && !alt_d_r))
    ? i_data_number_select : dnum_r;
  assign o_req.start_level = i_start || (i_alt_enable && i_alt_start);
endmodule : start_edge_detect
`default_nettype wire

// File: inc/start_ctl_pkg.sv
/*
  Package for the stored-operation start and override control block:
  register map, field positions, reset values and bus answers.
  Assumes a 32-bit Avalon-MM slave with word addressing of byte offsets.
*/
package start_ctl_pkg;
  localparam int ADDR_W = 4;
  localparam int DNUM_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 4'h8;
  // configuration field positions
  localparam int CFG_RAMP_BIT = 0;
  localparam int CFG_OVR_BIT = 1;
  localparam int CFG_AUTO_EXC_BIT = 2;
  localparam int CFG_ALT_FUNC_BIT = 3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0000_000F;
  // answer to an unmapped read
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic {RAMP_ACCEL_DECEL, RAMP_VEL_STOP_COMPAT} ramp_method_t;
endpackage : start_ctl_pkg

// File: inc/start_req_if.sv
/*
  Interface carrying start requests from the start detector to the controller.
  Assumes one clock shared by both modules.
*/
`timescale 1ns/1ps
`default_nettype none
interface start_req_if;
  logic start_pulse;
  logic alt_pulse;
  logic [7:0] dnum;
  logic start_level;
  modport src (output start_pulse, output alt_pulse, output dnum, output start_level);
  modport dst (input start_pulse, input alt_pulse, input dnum, input start_level);
endinterface : start_req_if
`default_nettype wire

// File: verif/host_start_model.sv
/* host side model: start handshake and data number select lines.
   assumes the block's ready output and one shared clock. */
`timescale 1ns/1ps
`default_nettype none
module host_start_model (
  input wire logic i_ref_clk,
  input wire logic i_ready,
  output logic o_start,
  output logic [7:0] o_select
);
  initial begin
    o_start = 1'b0;
    o_select = 8'h00;
  end
  // raw drive for one cycle, also used to break the handshake on purpose
  task automatic drive(input logic s, input logic [7:0] n);
    o_start <= s;
    o_select <= n;
    @(posedge i_ref_clk);
  endtask : drive
  // full handshake; select lines scrambled once released
  task automatic handshake(input logic [7:0] n);
    int k;
    k = 0;
    while (i_ready !== 1'b1 && k < 40) begin
      @(posedge i_ref_clk);
      k++;
    end
    drive(1'b1, n);
    k = 0;
    while (i_ready !== 1'b0 && k < 40) begin
      @(posedge i_ref_clk);
      k++;
    end
    drive(1'b0, ~n);
  endtask : handshake
endmodule : host_start_model
`default_nettype wire

// File: verif/tb.sv
/* self-checking bench for the start and override controller.
   assumes the package and the host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import start_ctl_pkg::*;
  logic clk, rst_n, rd, wr, alt, done, fwrv, start, ready, ops, run, sclr, exc, ramp, wreq;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wd, rdat, q;
  logic [7:0] sel, dn;
  int fail_count, n_compared, cyc, nst, nsc, n0;
  typedef struct packed {logic [3:0] cfg; logic fr; logic [7:0] num;} row_t;
  row_t rows [4] = '{'{4'h0, 1'b1, 8'h5A}, '{4'h1, 1'b1, 8'hFF}, '{4'h2, 1'b0, 8'h00},
    '{4'h7, 1'b1, 8'hA5}};
  motion_start_override_control dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_start(start), .i_alt_start(alt), .i_data_number_select(sel),
    .i_op_done(done), .i_forward_reverse_operation(fwrv), .o_stored_op_ready(ready),
    .o_op_start(ops), .o_op_data_number(dn), .o_op_running(run), .o_sequence_clear(sclr),
    .o_excitation_request(exc), .o_ramp_method(ramp));
  host_start_model host (.i_ref_clk(clk), .i_ready(ready), .o_start(start), .o_select(sel));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    nst += (ops === 1'b1);
    nsc += (sclr === 1'b1);
    if (cyc > 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic finish_op();
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : finish_op
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  initial begin
    {rst_n, rd, wr, alt, done, fwrv, adr, wd} = '0;
    {fail_count, n_compared, cyc, nst, nsc} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("ready_rst", ready, 1'b1);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("cfg_rst", q, CFG_RESET);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, UNMAPPED_RD);
    bus(1'b1, 4'hC, 32'h0000_000F);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("unmapped_wr", q, CFG_RESET);
    foreach (rows[i]) begin
      bus(1'b1, OFS_CONFIG, {28'h0, rows[i].cfg});
      fwrv <= rows[i].fr;
      bus(1'b0, OFS_CONFIG, 32'h0);
      chk("cfg", q, {28'h0, rows[i].cfg});
      chk("ramp", ramp, rows[i].cfg[CFG_RAMP_BIT]);
      chk("exc", exc, rows[i].cfg[CFG_AUTO_EXC_BIT] & rows[i].fr);
      host.handshake(rows[i].num);
      chk("dnum", dn, rows[i].num);
      chk("run", run, 1'b1);
      repeat (2) @(posedge clk);
      chk("ready_rel", ready, rows[i].cfg[CFG_OVR_BIT]);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", q, {30'h0, 1'b1, rows[i].cfg[CFG_OVR_BIT]});
      bus(1'b0, OFS_ACTIVE, 32'h0);
      chk("active", q, {24'h0, rows[i].num});
      finish_op();
      chk("ready_done", ready, 1'b1);
    end
    // override while running replaces data and clears sequence state
    bus(1'b1, OFS_CONFIG, 32'h2);
    host.handshake(8'h11);
    n0 = nsc;
    host.handshake(8'h22);
    chk("ovr_dnum", dn, 8'h22);
    chk("seq_clr", nsc, n0 + 1);
    // override off: a start while running is ignored
    bus(1'b1, OFS_CONFIG, 32'h0);
    n0 = nst;
    host.drive(1'b1, 8'h33);
    host.drive(1'b1, 8'h33);
    host.drive(1'b0, 8'h33);
    chk("no_ovr", dn, 8'h22);
    chk("no_ovr_n", nst, n0);
    finish_op();
    // alternate start ignored, then honoured with function bit set
    host.drive(1'b0, 8'h44);
    alt <= 1'b1;
    repeat (3) @(posedge clk);
    alt <= 1'b0;
    chk("alt_off", nst, n0);
    bus(1'b1, OFS_CONFIG, 32'h8);
    alt <= 1'b1;
    repeat (3) @(posedge clk);
    alt <= 1'b0;
    chk("alt_on", nst, n0 + 1);
    chk("alt_dnum", dn, 8'h44);
    // reset in mid-run drops the running operation and the settings
    rst_n <= 1'b0;
    @(posedge clk);
    chk("rst_ready", ready, 1'b1);
    chk("rst_run", run, 1'b0);
    chk("rst_dnum", dn, 8'h00);
    chk("rst_wait", wreq, 1'b1);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("cfg_rst2", q, CFG_RESET);
    chk("ramp_rst2", ramp, 1'b0);
    host.handshake(8'h66);
    chk("dnum_rst2", dn, 8'h66);
    test_done();
  end
endmodule : tb
`default_nettype wire
